// ---- rtl/lcc_pkg.sv ----
// lcc_pkg: constants, register map and carriers of the logic cluster
package lcc_pkg;

  // ==========================================================
  // cluster shape
  localparam int NCELL = 10;                 // cells per cluster
  localparam int SECT  = 5;                  // cells per carry-select section

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;   // cluster control word
  localparam logic [7:0] OFS_STAT = 8'h04;   // live register and carry state
  localparam logic [7:0] OFS_CELL = 8'h40;   // first cell word, one per cell
  localparam logic [7:0] OFS_NONE = 8'hFF;   // marks an address above the map

  // ==========================================================
  // control word bits
  localparam int CTL_ARITH = 0;              // dynamic arithmetic mode
  localparam int CTL_DEVCL = 1;              // device-wide clear honoured
  localparam int CTL_LINK  = 2;              // carry taken from previous cluster
  localparam int CTL_COUNT = 3;              // counter enable and up/down in use

  // ==========================================================
  // cell word fields
  localparam int CFG_MASK = 0;               // 16-bit truth table
  localparam int CFG_TYPE = 16;              // 2-bit register type
  localparam int CFG_I3C  = 18;              // lookup input 3 from carry
  localparam int CFG_FB   = 19;              // lookup input 0 from own register
  localparam int CFG_LCH  = 20;              // lookup input 2 from lookup chain
  localparam int CFG_SHF  = 21;              // register data from register chain
  localparam int CFG_CLRB = 22;              // second cluster clear used
  localparam int CFG_PRE  = 23;              // async load acts as preset
  localparam int CFG_OSEL = 24;              // 3 bits: output k from register

  localparam logic [1:0] TYP_D  = 2'h0;      // plain data
  localparam logic [1:0] TYP_T  = 2'h1;      // toggle
  localparam logic [1:0] TYP_JK = 2'h2;      // j from data, k from input 1
  localparam logic [1:0] TYP_SR = 2'h3;      // s from data, r from input 1

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic dev_clr_n;                         // device_wide_clear_n
    logic aclr_a;                            // first async clear
    logic aclr_b;                            // second async clear
    logic aload;                             // async load / preset
    logic sclr;                              // sync clear
    logic sload;                             // sync load
    logic clk_en;                            // clock enable
    logic addsub;                            // add_subtract_select, 1 = subtract
  } lcc_ctl_type;

  typedef struct packed {
    logic route_a;                           // row/column and adjacent link
    logic route_b;                           // row/column and adjacent link
    logic local_o;                           // local routing
  } lcc_cell_out_type;

  typedef struct packed {
    logic [31:0]            ctrl;            // control word
    logic [NCELL-1:0][31:0] cfg;             // cell words
    logic [NCELL-1:0]       q;               // cell registers
    logic [7:0]             addr;            // bus address of data phase
    logic                   wr;              // data phase is a write
    logic                   act;             // data phase pending
  } lcc_state_type;

endpackage

// ---- rtl/lcc_cluster.sv ----
// lcc_cluster: ten logic cells with carry-select chain and register slave
//
// Contract
// RULE_01 - lookup realises any four-input function
// RULE_02 - register acts as D, T, JK, SR
// RULE_03 - register has data, load, clock, enable, clears
// RULE_04 - async load data is fourth_data_input
// RULE_05 - combinational use bypasses the register
// RULE_06 - three outputs, each lookup or register
// RULE_07 - register feeds own lookup; both versions out
// RULE_08 - lookup chain and register chain cascades
// RULE_09 - subtract inverts operand b, carry-in one
// RULE_10 - first cell carry-in from add_subtract_select
// RULE_11 - normal or arithmetic mode, eight inputs steered
// RULE_12 - cluster controls always; add_subtract only arithmetic
// RULE_13 - normal: input 3 is carry or fourth_data_input
// RULE_14 - arithmetic: four two-input lookups, sums, carries
// RULE_15 - cluster carry picks chain, chain picks sum
// RULE_16 - each chain selects its own carry-out forward
// RULE_17 - counter enable, up/down, sync clear, load
// RULE_18 - cluster carry regenerated at fifth, tenth cell
// RULE_19 - chains continue through linked clusters
// RULE_20 - preset loads high; clear beats preset
// RULE_21 - two clears and one preset per cluster
// RULE_22 - enabled device clear overrides all controls
// RULE_23 - ten cells share cluster controls
// RULE_24 - disabled clock enable holds the register
//
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps

module lcc_cluster (
  input  wire logic                                  ref_clk_in,
  input  wire logic                                  nrst_in,
  input  wire logic                                  hsel_in,
  input  wire logic [31:0]                           haddr_in,
  input  wire logic [1:0]                            htrans_in,
  input  wire logic                                  hwrite_in,
  input  wire logic [2:0]                            hsize_in,
  input  wire logic [31:0]                           hwdata_in,
  input  wire logic                                  hready_in,
  output logic      [31:0]                           hrdata_out,
  output logic                                       hreadyout_out,
  output logic                                       hresp_out,
  input  wire lcc_pkg::lcc_ctl_type                  ctl_in,
  input  wire logic [lcc_pkg::NCELL-1:0][3:0]        cell_data_in,
  input  wire logic                                  carry_in_in,
  input  wire logic                                  lut_chain_in,
  input  wire logic                                  reg_chain_in,
  output lcc_pkg::lcc_cell_out_type [lcc_pkg::NCELL-1:0] cell_out,
  output logic                                       carry_out_out,
  output logic                                       lut_chain_out,
  output logic                                       reg_chain_out
);

  // ==========================================================
  // state and shared signals
  lcc_pkg::lcc_state_type st_q;              // all state
  lcc_pkg::lcc_state_type st_d;              // next state

  logic [lcc_pkg::NCELL:0]   ci0;            // carry_in_zero_chain per cell
  logic [lcc_pkg::NCELL:0]   ci1;            // carry_in_one_chain per cell
  logic [lcc_pkg::NCELL:0]   lch;            // lookup chain
  logic [lcc_pkg::NCELL:0]   rch;            // register chain
  logic [lcc_pkg::NCELL-1:0] res;            // lookup or sum result
  logic [lcc_pkg::NCELL-1:0] qe;             // register seen after async controls
  logic [lcc_pkg::NCELL-1:0] nx;             // register next value
  logic [lcc_pkg::NCELL-1:0] op_a;           // first_operand_input
  logic [lcc_pkg::NCELL-1:0] op_b;           // second operand after inversion
  logic [lcc_pkg::NCELL-1:0] acl;            // clear chosen by each cell
  logic [1:0]                sel;            // cluster carry per section
  logic                      arith;          // arithmetic mode
  logic                      cnt;            // counter controls active
  logic                      dev;            // device-wide clear acting
  logic [7:0]                rel;            // address relative to cell words
  logic                      cell_hit;       // data phase hits a cell word
  logic [3:0]                cell_sel;       // cell word index
  logic [31:0]               rdata;          // read mux

  assign arith = st_q.ctrl[lcc_pkg::CTL_ARITH];
  assign cnt   = arith & st_q.ctrl[lcc_pkg::CTL_COUNT];               // RULE_17
  assign dev   = ~ctl_in.dev_clr_n & st_q.ctrl[lcc_pkg::CTL_DEVCL];   // RULE_22

  // ==========================================================
  // carry-select sections
  assign ci0[0] = 1'b0;
  assign ci1[0] = 1'b1;
  // first section: add_subtract_select or previous cluster
  assign sel[0] = st_q.ctrl[lcc_pkg::CTL_LINK] ? carry_in_in           // RULE_19
                                               : arith & ctl_in.addsub; // RULE_10
  // second section regenerated from the fifth cell
  assign sel[1] = sel[0] ? ci1[lcc_pkg::SECT] : ci0[lcc_pkg::SECT];    // RULE_18
  // cluster carry out from the tenth cell
  assign carry_out_out = sel[1] ? ci1[lcc_pkg::NCELL]
                                : ci0[lcc_pkg::NCELL];                 // RULE_18
  assign lch[0]        = lut_chain_in;
  assign rch[0]        = reg_chain_in;
  assign lut_chain_out = lch[lcc_pkg::NCELL];                          // RULE_08
  assign reg_chain_out = rch[lcc_pkg::NCELL];                          // RULE_08

  // ==========================================================
  // one logic cell per pass, all on the shared controls
  for (genvar i = 0; i < lcc_pkg::NCELL; i++) begin : g_cell           // RULE_23
    logic [31:0] c;                          // cell word
    logic [3:0]  d;                          // local data inputs
    logic        z;                          // zero chain into cell
    logic        o;                          // one chain into cell
    logic        cy;                         // carry seen by cell
    logic        sub;                        // invert operand b
    logic        s0;                         // sum for carry 0
    logic        s1;                         // sum for carry 1
    logic        co0;                        // carry out for carry 0
    logic        co1;                        // carry out for carry 1
    logic [3:0]  idx;                        // lookup address
    logic        lut;                        // four-input result
    logic        pv;                         // async load value
    logic        ds;                         // register data
    logic        fn;                         // type function result
    logic        hold;                       // no update this edge

    assign c = st_q.cfg[i];
    assign d = cell_data_in[i];

    // sections restart the chains at their first cell
    assign z = (i % lcc_pkg::SECT == 0) ? 1'b0 : ci0[i];
    assign o = (i % lcc_pkg::SECT == 0) ? 1'b1 : ci1[i];

    // down-count flips the operand like a subtraction
    assign sub     = arith & (ctl_in.addsub ^ (cnt & ~d[3]));          // RULE_12 RULE_17
    assign op_a[i] = d[0];
    assign op_b[i] = d[1] ^ sub;                                       // RULE_09

    // four two-input lookups
    assign s0  = op_a[i] ^ op_b[i];                                    // RULE_14
    assign s1  = ~s0;                                                  // RULE_14
    assign co0 = op_a[i] & op_b[i];                                    // RULE_14
    assign co1 = op_a[i] | op_b[i];                                    // RULE_14

    // cluster carry picks the chain
    assign cy       = sel[i / lcc_pkg::SECT] ? o : z;                  // RULE_15
    // each chain selects its own carry-out
    assign ci0[i+1] = z ? co1 : co0;                                   // RULE_16
    assign ci1[i+1] = o ? co1 : co0;                                   // RULE_16

    // normal mode lookup inputs, steered by the cell word
    assign idx[0] = c[lcc_pkg::CFG_FB]  ? qe[i] : d[0];                // RULE_07
    assign idx[1] = d[1];
    assign idx[2] = c[lcc_pkg::CFG_LCH] ? lch[i] : d[2];               // RULE_08
    assign idx[3] = c[lcc_pkg::CFG_I3C] ? cy : d[3];                   // RULE_13
    assign lut    = c[lcc_pkg::CFG_MASK + int'(idx)];                  // RULE_01

    // mode choice: sum or lookup
    assign res[i]   = arith ? (cy ? s1 : s0) : lut;                    // RULE_11 RULE_15
    assign lch[i+1] = res[i];

    // one of two cluster clears, one preset
    assign acl[i] = c[lcc_pkg::CFG_CLRB] ? ctl_in.aclr_b : ctl_in.aclr_a; // RULE_21
    assign pv     = c[lcc_pkg::CFG_PRE] ? 1'b1 : d[3];                 // RULE_04 RULE_20

    // async controls act on the output at once
    assign qe[i] = dev ? 1'b0
                 : acl[i] ? 1'b0                                       // RULE_20
                 : ctl_in.aload ? pv                                   // RULE_03
                 : st_q.q[i];
    assign rch[i+1] = qe[i];

    // register data: result or register chain
    assign ds = c[lcc_pkg::CFG_SHF] ? rch[i] : res[i];                 // RULE_08

    // register type function
    always_comb begin : p_type
      case (c[lcc_pkg::CFG_TYPE +: 2])                                 // RULE_02
        lcc_pkg::TYP_T:  fn = st_q.q[i] ^ ds;
        lcc_pkg::TYP_JK: fn = (ds & ~st_q.q[i]) | (~d[1] & st_q.q[i]);
        lcc_pkg::TYP_SR: fn = ds | (~d[1] & st_q.q[i]);
        default:         fn = ds;
      endcase
    end

    // counter enable from third input, clock enable always
    assign hold = ~ctl_in.clk_en | (cnt & ~d[2]);                      // RULE_24 RULE_17

    // priority: device clear, clear, load, hold, sync clear, sync load
    assign nx[i] = (dev | acl[i]) ? 1'b0                               // RULE_22 RULE_20
                 : ctl_in.aload ? pv
                 : hold ? st_q.q[i]                                    // RULE_24
                 : ctl_in.sclr ? 1'b0                                  // RULE_12
                 : ctl_in.sload ? d[3]                                 // RULE_12
                 : fn;

    // outputs independently from lookup or register
    assign cell_out[i].route_a = c[lcc_pkg::CFG_OSEL]   ? qe[i] : res[i]; // RULE_06 RULE_05
    assign cell_out[i].route_b = c[lcc_pkg::CFG_OSEL+1] ? qe[i] : res[i]; // RULE_06 RULE_07
    assign cell_out[i].local_o = c[lcc_pkg::CFG_OSEL+2] ? qe[i] : res[i]; // RULE_06
  end

  // ==========================================================
  // bus decode of the data phase
  assign rel      = st_q.addr - lcc_pkg::OFS_CELL;
  assign cell_hit = (st_q.addr >= lcc_pkg::OFS_CELL) && (rel[1:0] == 2'h0)
                    && (rel[7:2] < 6'(lcc_pkg::NCELL));
  assign cell_sel = rel[5:2];

  // read mux from flops and live cell state
  always_comb begin : p_rdata
    rdata = 32'h0000_0000;
    if (st_q.addr == lcc_pkg::OFS_CTRL) begin
      rdata = st_q.ctrl;
    end else if (st_q.addr == lcc_pkg::OFS_STAT) begin
      rdata = {21'h00_0000, carry_out_out, qe};
    end else if (cell_hit) begin
      rdata = st_q.cfg[cell_sel];
    end
  end

  assign hrdata_out    = rdata;
  assign hreadyout_out = 1'b1;               // zero wait states
  assign hresp_out     = 1'b0;               // always okay

  // ==========================================================
  // next state
  always_comb begin : p_next
    st_d   = st_q;
    st_d.q = nx;
    // data phase write
    if (st_q.act && st_q.wr) begin
      if (st_q.addr == lcc_pkg::OFS_CTRL) begin
        st_d.ctrl = hwdata_in;
      end else if (cell_hit) begin
        st_d.cfg[cell_sel] = hwdata_in;
      end
    end
    // address phase capture
    if (hready_in) begin
      st_d.act  = hsel_in & htrans_in[1];
      st_d.wr   = hwrite_in;
      st_d.addr = (haddr_in[31:8] == 24'h00_0000) ? haddr_in[7:0]
                                                  : lcc_pkg::OFS_NONE;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin : p_state
    if (!nrst_in) begin
      st_q      <= '0;
      st_q.ctrl <= lcc_pkg::CTRL_RST;
      st_q.cfg  <= {lcc_pkg::NCELL{lcc_pkg::CFG_RST}};
      st_q.addr <= lcc_pkg::OFS_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  logic quiet;                               // no control other than data moves
  assign quiet = ctl_in.clk_en & ~ctl_in.sclr & ~ctl_in.sload & ~ctl_in.aload
                 & ~ctl_in.aclr_a & ~ctl_in.aclr_b & ~dev & ~cnt;

  chk_clear_wins: assert property ( // RULE_20
    (acl[0] && ctl_in.aload) |-> !qe[0])
    else $error("clear lost against load");

  chk_preset_high: assert property ( // RULE_20
    (ctl_in.aload && !acl[0] && !dev && st_q.cfg[0][lcc_pkg::CFG_PRE]) |-> qe[0])
    else $error("preset did not load high");

  chk_aload_data: assert property ( // RULE_04
    (ctl_in.aload && !acl[1] && !dev && !st_q.cfg[1][lcc_pkg::CFG_PRE])
    |-> qe[1] == cell_data_in[1][3])
    else $error("async load not from fourth input");

  chk_dev_clear: assert property ( // RULE_22
    dev |=> (st_q.q == '0))
    else $error("device clear left a register set");

  chk_enable_hold: assert property ( // RULE_24
    (!ctl_in.clk_en && !ctl_in.aload && !ctl_in.aclr_a && !ctl_in.aclr_b && !dev)
    |=> st_q.q == $past(st_q.q))
    else $error("register moved without clock enable");

  chk_shift_chain: assert property ( // RULE_08
    (quiet && st_q.cfg[1][lcc_pkg::CFG_SHF]
     && st_q.cfg[1][lcc_pkg::CFG_TYPE +: 2] == lcc_pkg::TYP_D)
    |=> st_q.q[1] == $past(qe[0]))
    else $error("register chain did not shift");

  chk_sum_value: assert property ( // RULE_15
    (arith && !cnt && !st_q.ctrl[lcc_pkg::CTL_LINK])
    |-> {carry_out_out, res} == ({1'b0, op_a} + {1'b0, op_b} + {10'h000, ctl_in.addsub}))
    else $error("cluster sum wrong");

  chk_sub_invert: assert property ( // RULE_09
    (arith && !cnt && ctl_in.addsub) |-> (op_b == ~{cell_data_in[9][1], cell_data_in[8][1],
      cell_data_in[7][1], cell_data_in[6][1], cell_data_in[5][1], cell_data_in[4][1],
      cell_data_in[3][1], cell_data_in[2][1], cell_data_in[1][1], cell_data_in[0][1]}))
    else $error("second operand not inverted");

  chk_sync_clear: assert property ( // RULE_12
    (ctl_in.sclr && ctl_in.clk_en && !ctl_in.aload && !ctl_in.aclr_a
     && !ctl_in.aclr_b && !dev && !cnt) |=> st_q.q == '0)
    else $error("sync clear missed");

endmodule // lcc_cluster

// ---- sim/lcc_fabric.sv ----
// lcc_fabric: neighbouring cells and routing that feed the cluster
`timescale 1ns/10ps

module lcc_fabric (
  input  wire logic                           ref_clk_in, // cluster clock
  input  wire logic                           nrst_in,    // async reset, active low
  input  wire logic [lcc_pkg::NCELL-1:0][3:0] want_in,    // data the bench asks for
  input  wire logic [2:0]                     chain_in,   // carry, lookup, register chain
  output logic      [lcc_pkg::NCELL-1:0][3:0] data_out,   // routed cell data
  output logic      [2:0]                     chain_out   // routed chain signals
);
  // ====================
  // routing launches new values just after each rising edge
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_out  <= '0;
      chain_out <= '0;
    end else begin
      data_out  <= want_in;
      chain_out <= chain_in;
    end
  end
endmodule // lcc_fabric

// ---- sim/testbench.sv ----
// testbench: self-checking bench for the logic cluster
`timescale 1ns/10ps

module testbench;
  // ====================
  // signals
  logic                                 clk, nrst, hsel, hwrite, hready, hresp;
  logic [1:0]                           htrans;
  logic [31:0]                          haddr, hwdata, hrdata, rd, rnd;
  lcc_pkg::lcc_ctl_type                 ctl;       // cluster controls
  logic [9:0][3:0]                      want, dat; // cell data asked and routed
  logic [2:0]                           chw, chn;  // chain inputs asked and routed
  lcc_pkg::lcc_cell_out_type [9:0]      cout;      // cell outputs
  logic                                 carry_out, lut_out, reg_out;
  logic [9:0]                           a, b, got;
  logic [10:0]                          sum;
  logic                                 s;
  logic [31:0]                          exp_q[$], got_q[$]; // notes and results
  int                                   bad_count, check_count;
  event                                 seen;
  // register steps: {ctl, data nibble, expected view}
  localparam logic [12:0] STEPS [10] = '{{8'h82, 4'h1, 1'b1}, {8'h80, 4'h0, 1'b1},
    {8'h88, 4'h0, 1'b1}, {8'h8a, 4'h1, 1'b0}, {8'hd0, 4'h0, 1'b0}, {8'h90, 4'h0, 1'b1},
    {8'h10, 4'h0, 1'b0}, {8'h86, 4'h8, 1'b1}, {8'h90, 4'h8, 1'b1}, {8'h90, 4'h0, 1'b0}};

  lcc_fabric fab (.ref_clk_in(clk), .nrst_in(nrst), .want_in(want), .chain_in(chw),
    .data_out(dat), .chain_out(chn));
  lcc_cluster DUT (.ref_clk_in(clk), .nrst_in(nrst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .ctl_in(ctl), .cell_data_in(dat), .carry_in_in(chn[0]), .lut_chain_in(chn[1]),
    .reg_chain_in(chn[2]), .cell_out(cout), .carry_out_out(carry_out),
    .lut_chain_out(lut_out), .reg_chain_out(reg_out));

  // ====================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one single ahb-lite word transfer, waits bounded
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, ad};
    hwrite <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 40) begin
      bad_count++;
      $display("wrong value at %0t: bus wait ran out", $time);
      wrap_up();
    end
  endtask

  // let the fabric launch the data, then look at settled outputs
  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic expect_val(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
    -> seen;
  endtask

  // ====================
  // monitor: oldest note against oldest result
  always @(seen) begin
    while (exp_q.size() > 0) begin
      check_count++;
      if (got_q[0] !== exp_q[0]) begin
        bad_count++;
        $display("wrong value at %0t: got %h want %h", $time, got_q[0], exp_q[0]);
      end
      void'(exp_q.pop_front());
      void'(got_q.pop_front());
    end
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ====================
  // main sequence
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, want, chw} = '0;
    ctl = 8'h80;
    nrst = 1'b0;
    rnd = 32'h0000_0ea1;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    // register map, reset values, dropped writes
    bus(1'b0, lcc_pkg::OFS_CTRL, 32'h0000_0000);
    expect_val(lcc_pkg::CTRL_RST, rd);
    bus(1'b0, lcc_pkg::OFS_CELL + 8'h0c, 32'h0000_0000);
    expect_val(lcc_pkg::CFG_RST, rd);
    bus(1'b1, lcc_pkg::OFS_STAT, 32'hffff_ffff);
    bus(1'b0, lcc_pkg::OFS_STAT, 32'h0000_0000);
    expect_val(32'h0000_0000, rd);
    bus(1'b1, 8'h80, 32'hffff_ffff);
    bus(1'b0, 8'h80, 32'h0000_0000);
    expect_val(32'h0000_0000, rd);
    $display("test registers done");
    // every truth table entry of every cell on all three outputs
    for (int k = 0; k < 10; k++) begin
      rnd = lfsr(rnd);
      bus(1'b1, lcc_pkg::OFS_CELL + 8'(4 * k), {16'h0000, rnd[15:0]});
      bus(1'b0, lcc_pkg::OFS_CELL + 8'(4 * k), 32'h0000_0000);
      expect_val({16'h0000, rnd[15:0]}, rd);
      for (int i = 0; i < 16; i++) begin
        @(posedge clk);
        want[k] <= 4'(i);
        chw <= rnd[18:16];
        settle();
        expect_val({29'h0, {3{rnd[i]}}}, {29'h0, cout[k]});
      end
    end
    $display("test lookup done");
    // add and subtract across both carry-select sections
    bus(1'b1, lcc_pkg::OFS_CTRL, 32'h0000_0001);
    for (int t = 0; t < 16; t++) begin
      rnd = lfsr(rnd);
      a = (t < 2) ? {10{t == 0}} : rnd[9:0];
      b = (t < 2) ? 10'h001 >> t : rnd[19:10];
      s = t[0];
      @(posedge clk);
      ctl.addsub <= s;
      for (int k = 0; k < 10; k++) want[k] <= {2'b00, b[k], a[k]};
      settle();
      sum = {1'b0, a} + {1'b0, b ^ {10{s}}} + 11'(s);
      for (int k = 0; k < 10; k++) got[k] = cout[k].route_a;
      expect_val({21'h0, sum}, {21'h0, carry_out, got});
    end
    // carry taken from the previous cluster
    bus(1'b1, lcc_pkg::OFS_CTRL, 32'h0000_0005);
    @(posedge clk);
    ctl.addsub <= 1'b0;
    chw <= 3'b001;
    settle();
    sum = {1'b0, a} + {1'b0, b} + 11'h001;
    for (int k = 0; k < 10; k++) got[k] = cout[k].route_a;
    expect_val({21'h0, sum}, {21'h0, carry_out, got});
    // count mode, down direction inverts operand b, counter enabled
    bus(1'b1, lcc_pkg::OFS_CTRL, 32'h0000_0009);
    @(posedge clk);
    chw <= 3'b000;
    for (int k = 0; k < 10; k++) want[k] <= {2'b01, b[k], a[k]};
    settle();
    sum = {1'b0, a} + {1'b0, ~b};
    for (int k = 0; k < 10; k++) got[k] = cout[k].route_a;
    expect_val({21'h0, sum}, {21'h0, carry_out, got});
    $display("test arithmetic done");
    // register chain shifts through cells 0 and 1
    bus(1'b1, lcc_pkg::OFS_CTRL, 32'h0000_0000);
    bus(1'b1, lcc_pkg::OFS_CELL, 32'h0120_0000);
    bus(1'b1, lcc_pkg::OFS_CELL + 8'h04, 32'h0120_0000);
    @(posedge clk);
    ctl <= 8'h82;
    chw <= 3'b100;
    settle();
    @(negedge clk);
    expect_val(32'h0000_0003, {30'h0, cout[1].route_a, cout[0].route_a});
    $display("test shift chain done");
    // register controls on cell 0, preset first, then data load
    bus(1'b1, lcc_pkg::OFS_CTRL, 32'h0000_0002);
    bus(1'b1, lcc_pkg::OFS_CELL, 32'h0180_aaaa);
    for (int i = 0; i < 10; i++) begin
      if (i == 8) bus(1'b1, lcc_pkg::OFS_CELL, 32'h0100_aaaa);
      @(posedge clk);
      ctl <= STEPS[i][12:5];
      want[0] <= STEPS[i][4:1];
      settle();
      expect_val({31'h0, STEPS[i][0]}, {31'h0, cout[0].route_a});
      bus(1'b0, lcc_pkg::OFS_STAT, 32'h0000_0000);
      expect_val({31'h0, STEPS[i][0]}, {31'h0, rd[0]});
    end
    $display("test register done");
    #1;
    wrap_up();
  end
endmodule // testbench
